// ==== edm_pkg.sv ====
`default_nettype none
package edm_pkg;

  // ==========================================================
  // Clock and conversion of times into cycles.
  localparam int CLK_PERIOD_NS = 100;

  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int floor_cyc(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // ==========================================================
  // Organisation of the memory module.
  localparam int WORD_ADDR_W = 22;
  localparam int PIN_ADDR_W = 11;
  localparam int COL_LSB = 0;
  localparam int ROW_LSB = 11;
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int RAS_W = 2;
  localparam int PD_W = 4;

  // ==========================================================
  // Strobe levels.
  localparam logic [RAS_W-1:0] RAS_OFF = 2'h3;
  localparam logic [RAS_W-1:0] RAS_ON = 2'h0;
  localparam logic [LANES-1:0] CAS_OFF = 4'hF;
  localparam logic [LANES-1:0] CAS_ALL_ON = 4'h0;

  // ==========================================================
  // Speed grades on the presence detect pins, pin 0 in bit 0.
  localparam logic [PD_W-1:0] PD_FAST = 4'hE;
  localparam logic [PD_W-1:0] PD_SLOW = 4'hA;

  // ==========================================================
  // Row timing per grade.
  localparam int CNT_W = 4;
  localparam int TRP_FAST_NS = 40;
  localparam int TRP_SLOW_NS = 50;
  localparam int TRAS_FAST_NS = 60;
  localparam int TRAS_SLOW_NS = 70;
  localparam logic [CNT_W-1:0] RP_CYC_FAST = CNT_W'(ceil_cyc(TRP_FAST_NS));
  localparam logic [CNT_W-1:0] RP_CYC_SLOW = CNT_W'(ceil_cyc(TRP_SLOW_NS));
  localparam logic [CNT_W-1:0] RAS_CYC_FAST = CNT_W'(ceil_cyc(TRAS_FAST_NS));
  localparam logic [CNT_W-1:0] RAS_CYC_SLOW = CNT_W'(ceil_cyc(TRAS_SLOW_NS));

  // ==========================================================
  // Refresh rate and longest open page.
  localparam int REF_WINDOW_NS = 32000000;
  localparam int REF_CYCLES = 2048;
  localparam int REF_INT_NS = REF_WINDOW_NS / REF_CYCLES;
  localparam int REF_W = 8;
  localparam logic [REF_W-1:0] REF_RELOAD = REF_W'(floor_cyc(REF_INT_NS) - 1);
  localparam int RASP_MAX_NS = 125000;
  localparam int RASP_W = 12;
  localparam int RASP_MARGIN_CYC = 8;
  localparam logic [RASP_W-1:0] RASP_CYC = RASP_W'(floor_cyc(RASP_MAX_NS));
  localparam logic [RASP_W-1:0] RASP_LIMIT = RASP_W'(floor_cyc(RASP_MAX_NS) - RASP_MARGIN_CYC);

  // ==========================================================
  // Controller states.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ROW = 4'h1,
    ST_RAS = 4'h2,
    ST_COL = 4'h3,
    ST_CAS = 4'h4,
    ST_CASUP = 4'h5,
    ST_OPEN = 4'h6,
    ST_TOFF = 4'h7,
    ST_PRE = 4'h8,
    ST_REF_CAS = 4'h9,
    ST_REF_RAS = 4'hA
  } edm_state_t;

endpackage
`default_nettype wire

// ==== edm_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module edm_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // ==========================================================
  // Two flip-flop synchroniser for pin inputs.
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
    end
  end

  assign q = s2_r;

endmodule // edm_sync
`default_nettype wire

// ==== edm_ctrl.sv ====
// Function
// - The write strobe stays high through and after the column strobe of every read.
// - The write strobe falls a cycle before the column strobe, so every write is an early write.
// - Write data and write strobe are held a full cycle after the column strobe falls.
// - Page accesses keep the row strobe low, pulse the column strobe and close the row in time.
// - Reads end with both strobes high, and the bus is never driven while the device may drive.
// - The device output in an open page is turned off by a write-strobe low pulse with the column strobe high.
// - For refresh the column strobes fall a full cycle before the row strobes.
// - One refresh is issued every 156 cycles (15600 ns) so that 2048 rows are covered in 32 ms.
// - Row and column go out on 11 multiplexed address pins with two row and four column strobes.
`timescale 1ns/1ps
`default_nettype none
module edm_ctrl
  import edm_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic req_valid,
  input wire logic req_we,
  input wire logic [WORD_ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic [LANES-1:0] req_be,
  output logic req_ready,
  output logic rd_valid,
  output logic [DATA_W-1:0] rd_data,
  output logic grade_slow,
  output logic [PIN_ADDR_W-1:0] dram_addr,
  output logic [RAS_W-1:0] dram_ras_n,
  output logic [LANES-1:0] dram_cas_n,
  output logic dram_we_n,
  output logic [DATA_W-1:0] data_lines_o,
  output logic data_lines_oe,
  input wire logic [DATA_W-1:0] data_lines_i,
  input wire logic [PD_W-1:0] presence_detect_pins
);

  // ==========================================================
  // Pin synchronisers.
  logic [DATA_W-1:0] dq_s;
  logic [PD_W-1:0] pd_s;

  edm_sync #(.W(DATA_W)) u_dq_sync (
    .mclk(mclk),
    .rstn(rstn),
    .d(data_lines_i),
    .q(dq_s)
  );

  edm_sync #(.W(PD_W)) u_pd_sync (
    .mclk(mclk),
    .rstn(rstn),
    .d(presence_detect_pins),
    .q(pd_s)
  );

  // ==========================================================
  // State.
  edm_state_t st_r, st_nxt;
  logic cmd_vld_r, cmd_we_r, dev_drv_r, ref_pend_r, rd_p0_r, rd_p1_r;
  logic grade_slow_r, req_ready_r, rd_valid_r, we_n_r, dq_oe_r;
  logic [WORD_ADDR_W-1:0] cmd_addr_r;
  logic [DATA_W-1:0] cmd_wdata_r, rd_data_r, dq_out_r;
  logic [LANES-1:0] cmd_be_r, cas_n_r;
  logic [RAS_W-1:0] ras_n_r;
  logic [PIN_ADDR_W-1:0] addr_r, open_row_r;
  logic [CNT_W-1:0] cnt_r;
  logic [REF_W-1:0] ref_cnt_r;
  logic [RASP_W-1:0] open_cnt_r;

  // ==========================================================
  // Decoding.
  wire accept = req_valid & req_ready_r;
  wire serve_done = (st_r == ST_CASUP);
  wire cmd_vld_nxt = accept | (cmd_vld_r & ~serve_done);
  wire [PIN_ADDR_W-1:0] cmd_row = cmd_addr_r[ROW_LSB +: PIN_ADDR_W];
  wire [PIN_ADDR_W-1:0] cmd_col = cmd_addr_r[COL_LSB +: PIN_ADDR_W];
  wire row_hit = (cmd_row == open_row_r);
  wire page_expire = (open_cnt_r >= RASP_LIMIT);
  wire cnt_zero = (cnt_r == '0);
  wire ref_tick = (ref_cnt_r == '0);
  wire ref_start = (st_r == ST_REF_CAS);
  wire ref_pend_nxt = ref_tick | (ref_pend_r & ~ref_start);
  wire [CNT_W-1:0] rp_cyc = grade_slow_r ? RP_CYC_SLOW : RP_CYC_FAST;
  wire [CNT_W-1:0] ras_cyc = grade_slow_r ? RAS_CYC_SLOW : RAS_CYC_FAST;
  wire enter_pre = (st_nxt == ST_PRE) & (st_r != ST_PRE);
  wire enter_ref = (st_nxt == ST_REF_RAS) & (st_r != ST_REF_RAS);
  wire [CNT_W-1:0] cnt_nxt = enter_pre ? rp_cyc - CNT_W'(1) :
                             enter_ref ? ras_cyc - CNT_W'(1) :
                             cnt_zero ? cnt_r : cnt_r - CNT_W'(1);
  wire in_xfer = (st_nxt inside {ST_COL, ST_CAS, ST_CASUP});
  wire ras_low = (st_nxt inside {ST_RAS, ST_COL, ST_CAS, ST_CASUP, ST_OPEN, ST_TOFF,
                                 ST_REF_RAS});
  wire in_page = (st_r inside {ST_RAS, ST_COL, ST_CAS, ST_CASUP, ST_OPEN, ST_TOFF});
  wire [RAS_W-1:0] ras_nxt = ras_low ? RAS_ON : RAS_OFF;
  wire [LANES-1:0] cas_nxt = (st_nxt == ST_CAS) ? ~cmd_be_r :
                             (st_nxt inside {ST_REF_CAS, ST_REF_RAS}) ? CAS_ALL_ON :
                             CAS_OFF;
  wire [PIN_ADDR_W-1:0] addr_nxt = (st_nxt inside {ST_ROW, ST_RAS}) ? cmd_row :
                                   in_xfer ? cmd_col : addr_r;
  wire we_nxt_n = ~((cmd_we_r & in_xfer) | (st_nxt == ST_TOFF));
  wire oe_nxt = cmd_we_r & in_xfer;
  wire rd_cap = (st_r == ST_CAS) & ~cmd_we_r;
  wire dev_drv_nxt = rd_cap | (dev_drv_r & ~(st_r inside {ST_TOFF, ST_PRE}));

  // ==========================================================
  // Next state.
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: begin
        if (ref_pend_r) begin
          st_nxt = ST_REF_CAS;
        end else if (cmd_vld_r) begin
          st_nxt = ST_ROW;
        end
      end
      ST_ROW: st_nxt = ST_RAS;
      ST_RAS: st_nxt = ST_COL;
      ST_COL: st_nxt = ST_CAS;
      ST_CAS: st_nxt = ST_CASUP;
      ST_CASUP: st_nxt = ST_OPEN;
      ST_OPEN: begin
        if (ref_pend_r | page_expire | (cmd_vld_r & ~row_hit)) begin
          st_nxt = ST_PRE;
        end else if (cmd_vld_r & cmd_we_r & dev_drv_r) begin
          st_nxt = ST_TOFF;
        end else if (cmd_vld_r) begin
          st_nxt = ST_COL;
        end else if (dev_drv_r) begin
          st_nxt = ST_TOFF;
        end
      end
      ST_TOFF: st_nxt = ST_OPEN;
      ST_PRE: begin
        if (cnt_zero) begin
          st_nxt = ST_IDLE;
        end
      end
      ST_REF_CAS: st_nxt = ST_REF_RAS;
      ST_REF_RAS: begin
        if (cnt_zero) begin
          st_nxt = ST_PRE;
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // ==========================================================
  // Registers.
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_r <= ST_IDLE;
      cmd_vld_r <= 1'b0;
      cmd_we_r <= 1'b0;
      cmd_addr_r <= '0;
      cmd_wdata_r <= '0;
      cmd_be_r <= '0;
      req_ready_r <= 1'b0;
      dev_drv_r <= 1'b0;
      ref_pend_r <= 1'b0;
      ref_cnt_r <= REF_RELOAD;
      open_cnt_r <= '0;
      open_row_r <= '0;
      cnt_r <= '0;
      rd_p0_r <= 1'b0;
      rd_p1_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r <= '0;
      grade_slow_r <= 1'b1;
      ras_n_r <= RAS_OFF;
      cas_n_r <= CAS_OFF;
      we_n_r <= 1'b1;
      addr_r <= '0;
      dq_oe_r <= 1'b0;
      dq_out_r <= '0;
    end else begin
      st_r <= st_nxt;
      cmd_vld_r <= cmd_vld_nxt;
      req_ready_r <= ~cmd_vld_nxt;
      if (accept) begin
        cmd_we_r <= req_we;
        cmd_addr_r <= req_addr;
        cmd_wdata_r <= req_wdata;
        cmd_be_r <= req_be;
      end
      dev_drv_r <= dev_drv_nxt;
      ref_pend_r <= ref_pend_nxt;
      ref_cnt_r <= ref_tick ? REF_RELOAD : ref_cnt_r - REF_W'(1);
      open_cnt_r <= in_page ? open_cnt_r + RASP_W'(1) : '0;
      if (st_r == ST_ROW) begin
        open_row_r <= cmd_row;
      end
      cnt_r <= cnt_nxt;
      rd_p0_r <= rd_cap;
      rd_p1_r <= rd_p0_r;
      rd_valid_r <= rd_p1_r;
      if (rd_p1_r) begin
        rd_data_r <= dq_s;
      end
      grade_slow_r <= (pd_s != PD_FAST);
      ras_n_r <= ras_nxt;
      cas_n_r <= cas_nxt;
      we_n_r <= we_nxt_n;
      addr_r <= addr_nxt;
      dq_oe_r <= oe_nxt;
      dq_out_r <= cmd_wdata_r;
    end
  end

  assign req_ready = req_ready_r;
  assign rd_valid = rd_valid_r;
  assign rd_data = rd_data_r;
  assign grade_slow = grade_slow_r;
  assign dram_addr = addr_r;
  assign dram_ras_n = ras_n_r;
  assign dram_cas_n = cas_n_r;
  assign dram_we_n = we_n_r;
  assign data_lines_o = dq_out_r;
  assign data_lines_oe = dq_oe_r;

  // ==========================================================
  // Assertions.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  sequence wr_hold_s;
    !we_n_r && dq_oe_r && (dq_out_r == $past(dq_out_r));
  endsequence

  sequence toff_pulse_s;
    (!we_n_r && (cas_n_r == CAS_OFF) && (ras_n_r == RAS_ON)) ##1 we_n_r;
  endsequence

  early_write_a: assert property (($fell(&cas_n_r) && !we_n_r) |-> $past(!we_n_r))
    else $error("write strobe not set up before column strobe");
  write_hold_a: assert property (($fell(&cas_n_r) && !we_n_r) |=> wr_hold_s)
    else $error("write data or strobe not held after column strobe");
  read_we_a: assert property (($fell(&cas_n_r) && we_n_r) |-> we_n_r [*2])
    else $error("write strobe fell during read");
  read_data_a: assert property ((st_r == ST_CAS && !cmd_we_r) |-> ##3 rd_valid_r)
    else $error("read data not delivered three cycles after column strobe");
  page_cycle_a: assert property ((st_r == ST_CAS) |=> (cas_n_r == CAS_OFF))
    else $error("column strobe not released after one cycle");
  page_max_a: assert property (open_cnt_r < RASP_CYC)
    else $error("row strobe held low too long");
  toff_a: assert property ((st_r == ST_OPEN && st_nxt == ST_TOFF) |=> toff_pulse_s)
    else $error("turn-off pulse malformed");
  contention_a: assert property (dq_oe_r |-> !dev_drv_r)
    else $error("data bus driven while device may drive");
  cbr_a: assert property (($fell(ras_n_r[0]) && !(&cas_n_r)) |-> $past(cas_n_r == CAS_ALL_ON))
    else $error("column strobe not set up before refresh row strobe");
  refresh_a: assert property ($rose(ref_pend_r) |-> ##[1:24] (st_r == ST_REF_CAS))
    else $error("refresh not started in time");
  grade_a: assert property ((pd_s != PD_FAST) |=> grade_slow_r)
    else $error("slow grade not selected for unknown pattern");

endmodule // edm_ctrl
`default_nettype wire

// ==== edm_dram_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module edm_dram_model
  import edm_pkg::*;
(
  input wire logic [PIN_ADDR_W-1:0] dram_addr,
  input wire logic [RAS_W-1:0] dram_ras_n,
  input wire logic [LANES-1:0] dram_cas_n,
  input wire logic dram_we_n,
  input wire logic [DATA_W-1:0] data_lines_o,
  output logic [DATA_W-1:0] data_lines_i,
  input wire logic [1:0] pd_mode,
  output logic [PD_W-1:0] presence_detect_pins,
  output logic dev_oe,
  output var int refresh_cnt,
  output var int rule_breaks
);
  // ==========================================================
  // Storage and strobe history.
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] dout;
  logic [PIN_ADDR_W-1:0] row;
  logic [LANES-1:0] cas_q;
  logic rd_cyc;
  realtime ras_t, cas_t, wr_t;
  initial begin
    dout = 32'h0; row = 11'h0; cas_q = 4'hF; rd_cyc = 0; dev_oe = 0;
    refresh_cnt = 0; rule_breaks = 0; ras_t = 0; cas_t = 0; wr_t = -1000;
  end
  // Released bus shows the inverse of the last value.
  assign data_lines_i = dev_oe ? dout : ~dout;
  assign presence_detect_pins = (pd_mode == 2'h1) ? 4'hE : (pd_mode == 2'h0) ? 4'hA : 4'hF;
  // ==========================================================
  // Column strobes: one byte lane each, early write or read.
  always @(dram_cas_n) begin
    for (int i = 0; i < LANES; i++) begin
      if (cas_q[i] && !dram_cas_n[i]) begin
        cas_t = $realtime;
        if (dram_ras_n[0] === 1'b0) begin
          if (dram_we_n === 1'b0) begin
            mem[{row, dram_addr}][8*i+:8] = data_lines_o[8*i+:8];
            wr_t = $realtime;
          end else begin
            dout[8*i+:8] = mem.exists({row, dram_addr}) ? mem[{row, dram_addr}][8*i+:8] : 8'h0;
            dev_oe = 1;
            rd_cyc = 1;
          end
        end
      end
    end
    if (&dram_cas_n) rd_cyc = 0;
    if ((&dram_cas_n) && dram_ras_n[0] && dram_we_n) dev_oe = 0;
    cas_q = dram_cas_n;
  end
  // ==========================================================
  // Row strobe: row latch, refresh and page age.
  always @(negedge dram_ras_n[0]) begin
    ras_t = $realtime;
    if (dram_cas_n !== 4'hF) begin
      if ($realtime - cas_t < 5) rule_breaks++;
      refresh_cnt++;
    end else begin
      row = dram_addr;
    end
  end
  always @(posedge dram_ras_n[0]) begin
    if ($realtime - ras_t > 125000) rule_breaks++;
    if ((&dram_cas_n) && dram_we_n) dev_oe = 0;
  end
  // ==========================================================
  // Write strobe: turn-off pulse and hold checks.
  always @(negedge dram_we_n) begin
    if (rd_cyc) rule_breaks++;
    if (&dram_cas_n) dev_oe = 0;
  end
  always @(posedge dram_we_n) if ($realtime - wr_t < 10) rule_breaks++;
  always @(data_lines_o) if ($realtime - wr_t < 10) rule_breaks++;
endmodule // edm_dram_model
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import edm_pkg::*;
  logic mclk, rstn, req_valid, req_we, req_ready, rd_valid, grade_slow;
  logic dram_we_n, data_lines_oe, dev_oe;
  logic [WORD_ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_wdata, rd_data, data_lines_o, data_lines_i, got;
  logic [LANES-1:0] req_be, dram_cas_n;
  logic [PIN_ADDR_W-1:0] dram_addr;
  logic [RAS_W-1:0] dram_ras_n;
  logic [PD_W-1:0] presence_detect_pins;
  logic [1:0] pd_mode;
  int refresh_cnt, rule_breaks, err_total, tests_run, r0;
  initial mclk = 0;
  always #50 mclk = ~mclk;
  edm_ctrl dut (.mclk(mclk), .rstn(rstn), .req_valid(req_valid), .req_we(req_we),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_be(req_be), .req_ready(req_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .grade_slow(grade_slow), .dram_addr(dram_addr),
    .dram_ras_n(dram_ras_n), .dram_cas_n(dram_cas_n), .dram_we_n(dram_we_n),
    .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe), .data_lines_i(data_lines_i),
    .presence_detect_pins(presence_detect_pins));
  edm_dram_model model (.dram_addr(dram_addr), .dram_ras_n(dram_ras_n),
    .dram_cas_n(dram_cas_n), .dram_we_n(dram_we_n), .data_lines_o(data_lines_o),
    .data_lines_i(data_lines_i), .pd_mode(pd_mode), .presence_detect_pins(presence_detect_pins),
    .dev_oe(dev_oe), .refresh_cnt(refresh_cnt), .rule_breaks(rule_breaks));
  // ==========================================================
  // Shared tasks.
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic give_verdict;
    if (err_total == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic issue(input logic we, input logic [21:0] a, input logic [31:0] d,
                       input logic [3:0] be);
    int n;
    n = 0;
    @(negedge mclk);
    req_valid = 1; req_we = we; req_addr = a; req_wdata = d; req_be = be;
    while (req_ready !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk(n < 40, 1);
    @(negedge mclk);
    req_valid = 0;
  endtask
  task automatic rd(input logic [21:0] a, output logic [31:0] d);
    int n;
    n = 0;
    issue(1'b0, a, 32'h0, 4'hF);
    while (rd_valid !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    chk(n < 40, 1);
    d = rd_data;
  endtask
  // Contention on the shared data bus is never allowed.
  always @(negedge mclk) if (data_lines_oe === 1'b1 && dev_oe === 1'b1) chk(1, 0);
  // ==========================================================
  // Scenarios.
  task automatic t_reset;
    chk({dram_ras_n, dram_cas_n, dram_we_n, data_lines_oe}, {2'h3, 4'hF, 1'b1, 1'b0});
    chk({grade_slow, req_ready, rd_valid}, 3'h4);
  endtask
  task automatic t_grade;
    pd_mode = 2'h1;
    repeat (6) @(negedge mclk);
    chk(grade_slow, 0);
    pd_mode = 2'h2;
    repeat (6) @(negedge mclk);
    chk(grade_slow, 1);
    pd_mode = 2'h0;
    repeat (6) @(negedge mclk);
    chk(grade_slow, 1);
    pd_mode = 2'h1;
    repeat (6) @(negedge mclk);
  endtask
  task automatic t_write_read;
    issue(1'b1, {11'h7FF, 11'h001}, 32'hA5C3_0F96, 4'hF);
    issue(1'b1, {11'h001, 11'h001}, 32'h1234_5678, 4'hF);
    rd({11'h7FF, 11'h001}, got);
    chk(got, 32'hA5C3_0F96);
    rd({11'h001, 11'h001}, got);
    chk(got, 32'h1234_5678);
    rd({11'h001, 11'h7FF}, got);
    chk(got, 32'h0);
  endtask
  task automatic t_lanes;
    pd_mode = 2'h0;
    issue(1'b1, {11'h055, 11'h2AA}, 32'h1122_3344, 4'hF);
    issue(1'b1, {11'h055, 11'h2AA}, 32'hAABB_CCDD, 4'h5);
    rd({11'h055, 11'h2AA}, got);
    chk(got, 32'h11BB_33DD);
  endtask
  task automatic t_page;
    int n;
    n = 0;
    issue(1'b1, {11'h123, 11'h010}, 32'hCAFE_0001, 4'hF);
    issue(1'b1, {11'h123, 11'h011}, 32'hCAFE_0002, 4'hF);
    rd({11'h123, 11'h010}, got);
    chk(got, 32'hCAFE_0001);
    rd({11'h123, 11'h011}, got);
    chk(got, 32'hCAFE_0002);
    while (dev_oe !== 1'b0 && n < 10) begin
      @(negedge mclk);
      n++;
    end
    chk(n < 10, 1);
  endtask
  task automatic t_refresh;
    repeat (10) @(negedge mclk);
    r0 = refresh_cnt;
    repeat (10 * (32000000 / 2048 / 100)) @(negedge mclk);
    chk(refresh_cnt - r0, 10);
    chk(rule_breaks, 0);
  endtask
  // ==========================================================
  // Main sequence and watchdog.
  initial begin
    err_total = 0; tests_run = 0; rstn = 0; req_valid = 0; req_we = 0;
    req_addr = 22'h0; req_wdata = 32'h0; req_be = 4'h0; pd_mode = 2'h0;
    repeat (8) @(negedge mclk);
    t_reset;
    rstn = 1;
    t_grade;
    t_write_read;
    t_lanes;
    t_page;
    t_refresh;
    give_verdict;
  end
  initial begin
    #(20000 * 100);
    err_total++;
    give_verdict;
  end
endmodule // testbench
`default_nettype wire
